// File: design/rtc_pkg.sv
/*
  Package for the ratiometric thermostat core: timing constants, the
  measurement sequencer states and the carrier structs shared by the
  sequencer and the decision logic.
  Assumes a single 25 MHz clock; all counts are derived from it here.
*/
package rtc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PER_NS    = 40;

  // Nominal measurement period and the faster period used when out of limits.
  localparam int unsigned PERIOD_MS     = 2000;
  localparam int unsigned FAST_MS       = 500;
  // Time the cap pin is forced to a known level before each timing interval.
  localparam int unsigned PRECHG_US     = 1000;
  // Longest charge or discharge allowed before an input counts as open.
  localparam int unsigned TIMEOUT_MS    = 500;
  // Shortest credible interval; anything faster counts as a shorted input.
  localparam int unsigned MINTIME_US    = 100;
  // Half period of the open-circuit warning blink on the indicator.
  localparam int unsigned BLINK_MS      = 50;

  // Derived cycle counts (integer division truncates, so every time rounds down).
  localparam int unsigned PERIOD_CYC    = PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned FAST_CYC      = FAST_MS * (CLK_HZ / 1000);
  localparam int unsigned PRECHG_CYC    = (PRECHG_US * (CLK_HZ / 1_000_000));
  localparam int unsigned TIMEOUT_CYC   = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned MINTIME_CYC   = (MINTIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BLINK_CYC     = BLINK_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // Decision constants
  // ==========================================================================
  // Hysteresis: leave the high state when sense*100 < ref*92 (about 8 %).
  localparam int unsigned HYST_NUM      = 92;
  localparam int unsigned HYST_DEN      = 100;
  // Successive agreeing measurements needed before the output may change.
  localparam logic [1:0]  CONSEC_N      = 2'h3;

  localparam int unsigned TW            = 32;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    RTC_IDLE   = 3'b000,
    RTC_PRE_LO = 3'b001,
    RTC_CHARGE = 3'b010,
    RTC_PRE_HI = 3'b011,
    RTC_DISCH  = 3'b100
  } rtc_state_e;

  // One finished measurement pair, handed to the decision logic.
  typedef struct packed {
    logic          valid;
    logic [TW-1:0] sense_t;
    logic [TW-1:0] ref_t;
  } rtc_meas_s;

  // Drive of one pin: level and output enable.
  typedef struct packed {
    logic drv;
    logic oe;
  } rtc_pin_s;

endpackage : rtc_pkg

// File: design/rtc_decide.sv
/*
  Thermostat decision logic: debounce over successive measurements and
  proportional hysteresis between the sense and reference times.
  Assumes measurement pairs arrive as one-cycle valid pulses and that the
  reset it receives is already synchronised.
*/
`timescale 1ns/1ps

module rtc_decide
  import rtc_pkg::*;
(
  input  wire logic      i_mclk,
  input  wire logic      i_rst_n,
  input  wire rtc_meas_s i_meas,
  output logic           o_out
);

  typedef struct packed {
    logic       out;
    logic [1:0] cnt;
  } rtc_dec_s;

  rtc_dec_s st_q;
  rtc_dec_s st_d;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // True when a*num < b*den; 64-bit math so large times cannot overflow.
  function automatic logic rtc_scaled_lt(input logic [TW-1:0] a,
                                         input logic [TW-1:0] b,
                                         input int unsigned   num,
                                         input int unsigned   den);
    logic [63:0] lhs;
    logic [63:0] rhs;
    lhs = 64'(a) * 64'(num);
    rhs = 64'(b) * 64'(den);
    return lhs < rhs;
  endfunction : rtc_scaled_lt

  // ==========================================================================
  // Next state
  // ==========================================================================
  // The counter only advances while the condition for a change holds, and
  // restarts from zero whenever one measurement disagrees.
  always_comb begin
    logic cond;
    cond = 1'b0;
    st_d = st_q;
    if (i_meas.valid) begin
      if (!st_q.out) begin
        cond = i_meas.sense_t > i_meas.ref_t;
      end else begin
        cond = rtc_scaled_lt(i_meas.sense_t, i_meas.ref_t,
                             HYST_DEN, HYST_NUM);
      end
      if (cond) begin
        if (st_q.cnt == CONSEC_N - 2'h1) begin
          st_d.out = ~st_q.out;
          st_d.cnt = 2'h0;
        end else begin
          st_d.cnt = st_q.cnt + 2'h1;
        end
      end else begin
        st_d.cnt = 2'h0;
      end
    end
  end

  // Reset leaves the output low with no count history.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_out = st_q.out;

endmodule : rtc_decide

// File: design/rtc_core.sv
/*
  Top of the ratiometric thermostat core: reset synchroniser, measurement
  sequencer that times the integrating capacitor through each resistor,
  open-circuit warning and measurement pacing.
  Assumes the cap pin input is a clean digital threshold level, that the
  pads resolve drive and enable, and that a supply-rise detector in the pad
  ring pulls i_rst_n low at power-up alongside the external reset pin.
*/
`timescale 1ns/1ps

module rtc_core
  import rtc_pkg::*;
#(
  parameter int unsigned P_PERIOD_CYC  = PERIOD_CYC,
  parameter int unsigned P_FAST_CYC    = FAST_CYC,
  parameter int unsigned P_PRECHG_CYC  = PRECHG_CYC,
  parameter int unsigned P_TIMEOUT_CYC = TIMEOUT_CYC,
  parameter int unsigned P_BLINK_CYC   = BLINK_CYC
)(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_cap_in,
  output logic      o_cap_drv,
  output logic      o_cap_oe,
  output logic      o_sense_drv,
  output logic      o_sense_oe,
  output logic      o_ref_drv,
  output logic      o_ref_oe,
  output logic      o_measuring_indicator,
  output logic      o_thermostat
);

  // ==========================================================================
  // Reset synchroniser
  // ==========================================================================
  // The pad pullup makes a floating pin read high, so a low level is a real
  // request; release is retimed so no flop leaves reset on a metastable edge.
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    rtc_state_e    st;
    logic          sel;      // 0 while timing sense, 1 while timing reference
    logic [TW-1:0] tmr;      // Time spent in the current phase.
    logic [TW-1:0] acc;      // Charge time of this resistor, before its discharge is added.
    logic [TW-1:0] per;      // Time since the last measurement started.
    logic [TW-1:0] blk;      // Warning blink timer.
    logic          blink;
    logic          open;     // An input was found open circuit.
    logic          fast;     // Last result was out of limits.
    rtc_meas_s     meas;
    rtc_pin_s      cap;
    rtc_pin_s      sense;
    rtc_pin_s      refr;
    logic          measuring_indicator;
  } rtc_core_s;

  rtc_core_s s_q;
  rtc_core_s s_d;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // True once a timer has spent the given number of cycles.
  function automatic logic rtc_elapsed(input logic [TW-1:0] t,
                                       input int unsigned   n);
    return t >= TW'(n - 1);
  endfunction : rtc_elapsed

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // Only the resistor under test is driven; the other pin floats, so no
  // current flows through it and it cannot disturb the interval.
  always_comb begin
    logic timeout;
    logic too_fast;
    logic [TW-1:0] total;
    timeout    = rtc_elapsed(s_q.tmr, P_TIMEOUT_CYC);
    too_fast   = 1'b0;
    total      = s_q.acc + s_q.tmr;
    s_d        = s_q;
    s_d.meas.valid = 1'b0;
    s_d.tmr    = s_q.tmr + TW'(1);
    if (s_q.per != '1) begin
      s_d.per = s_q.per + TW'(1);
    end

    // The warning blink runs free and is shown only between measurements.
    if (rtc_elapsed(s_q.blk, P_BLINK_CYC)) begin
      s_d.blk   = '0;
      s_d.blink = ~s_q.blink;
    end else begin
      s_d.blk = s_q.blk + TW'(1);
    end

    case (s_q.st)
      RTC_IDLE: begin
        s_d.cap   = '{drv: 1'b0, oe: 1'b0};
        s_d.sense = '{drv: 1'b0, oe: 1'b0};
        s_d.refr  = '{drv: 1'b0, oe: 1'b0};
        // Out-of-limits results shorten the period for a faster recovery.
        if (rtc_elapsed(s_q.per, s_q.fast ? P_FAST_CYC
                                          : P_PERIOD_CYC)) begin
          s_d.st  = RTC_PRE_LO;
          s_d.sel = 1'b0;
          s_d.per = '0;
          s_d.tmr = '0;
          s_d.acc = '0;
          s_d.cap = '{drv: 1'b0, oe: 1'b1};
        end
      end
      RTC_PRE_LO: begin
        if (rtc_elapsed(s_q.tmr, P_PRECHG_CYC)) begin
          s_d.st  = RTC_CHARGE;
          s_d.tmr = '0;
          s_d.cap = '{drv: 1'b0, oe: 1'b0};
          s_d.sense = '{drv: 1'b1, oe: !s_q.sel};
          s_d.refr  = '{drv: 1'b1, oe: s_q.sel};
        end
      end
      RTC_CHARGE: begin
        if (i_cap_in) begin
          s_d.st  = RTC_PRE_HI;
          s_d.acc = s_q.tmr;
          s_d.tmr = '0;
          s_d.sense = '{drv: 1'b0, oe: 1'b0};
          s_d.refr  = '{drv: 1'b0, oe: 1'b0};
          s_d.cap   = '{drv: 1'b1, oe: 1'b1};
        end else if (timeout) begin
          // Release the resistor pin too, or it would stay driven while the
          // indicator already shows idle.
          s_d.st    = RTC_IDLE;
          s_d.open  = 1'b1;
          s_d.fast  = 1'b1;
          s_d.sense = '{drv: 1'b0, oe: 1'b0};
          s_d.refr  = '{drv: 1'b0, oe: 1'b0};
        end
      end
      RTC_PRE_HI: begin
        if (rtc_elapsed(s_q.tmr, P_PRECHG_CYC)) begin
          s_d.st  = RTC_DISCH;
          s_d.tmr = '0;
          s_d.cap = '{drv: 1'b0, oe: 1'b0};
          s_d.sense = '{drv: 1'b0, oe: !s_q.sel};
          s_d.refr  = '{drv: 1'b0, oe: s_q.sel};
        end
      end
      RTC_DISCH: begin
        if (!i_cap_in) begin
          s_d.sense = '{drv: 1'b0, oe: 1'b0};
          s_d.refr  = '{drv: 1'b0, oe: 1'b0};
          s_d.tmr   = '0;
          too_fast  = total < TW'(MINTIME_CYC);
          if (!s_q.sel) begin
            s_d.meas.sense_t = total;
            s_d.sel = 1'b1;
            s_d.acc = '0;
            s_d.st  = RTC_PRE_LO;
            s_d.cap = '{drv: 1'b0, oe: 1'b1};
          end else begin
            // A shorted input still yields a result but speeds up pacing.
            s_d.meas.ref_t = total;
            s_d.meas.valid = 1'b1;
            s_d.st   = RTC_IDLE;
            s_d.open = 1'b0;
            s_d.fast = too_fast || (s_q.meas.sense_t < TW'(MINTIME_CYC));
          end
        end else if (timeout) begin
          s_d.st   = RTC_IDLE;
          s_d.open = 1'b1;
          s_d.fast = 1'b1;
          s_d.sense = '{drv: 1'b0, oe: 1'b0};
          s_d.refr  = '{drv: 1'b0, oe: 1'b0};
        end
      end
      default: begin
        s_d.st = RTC_IDLE;
      end
    endcase

    // Busy during every active phase; unless an input is open, the falling edge marks a new result
    // that reaches the thermostat output one cycle later.
    if (s_d.st != RTC_IDLE) begin
      s_d.measuring_indicator = 1'b1;
    end else begin
      s_d.measuring_indicator = s_d.open ? s_d.blink : 1'b0;
    end
  end

  // Reset leaves the timer saturated so a fresh measurement starts at once.
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q     <= '0;
      s_q.st  <= RTC_IDLE;
      s_q.per <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Decision logic
  // ==========================================================================
  rtc_decide u_decide (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_sync_q),
    .i_meas  (s_q.meas),
    .o_out   (o_thermostat)
  );

  // ==========================================================================
  // Pins
  // ==========================================================================
  assign o_cap_drv             = s_q.cap.drv;
  assign o_cap_oe              = s_q.cap.oe;
  assign o_sense_drv           = s_q.sense.drv;
  assign o_sense_oe            = s_q.sense.oe;
  assign o_ref_drv             = s_q.refr.drv;
  assign o_ref_oe              = s_q.refr.oe;
  assign o_measuring_indicator = s_q.measuring_indicator;

endmodule : rtc_core

// File: tb/rtc_monitor.sv
/*
  Checker for the thermostat core: pin sequencing, indicator, debounce and pacing.
  Assumes it is bound into rtc_core and sees only its ports.
*/
`timescale 1ns/1ps

module rtc_monitor
  import rtc_pkg::*;
#(
  parameter int unsigned P_PERIOD_CYC = PERIOD_CYC,
  parameter int unsigned P_FAST_CYC   = FAST_CYC,
  parameter int unsigned P_PRECHG_CYC = PRECHG_CYC
)(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_cap_in,
  input wire logic o_cap_drv,
  input wire logic o_cap_oe,
  input wire logic o_sense_drv,
  input wire logic o_sense_oe,
  input wire logic o_ref_drv,
  input wire logic o_ref_oe,
  input wire logic o_measuring_indicator,
  input wire logic o_thermostat
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic        cap_q;
  logic        sen_q;
  logic        ref_q;
  logic        therm_q;
  logic        gap_v_q;
  logic [2:0]  ends_q;
  int unsigned gap_q;
  logic        start;
  logic        meas_end;

  // A start is the cap pin forced with no resistor active just before it.
  assign start    = o_cap_oe && !cap_q && !sen_q && !ref_q;
  assign meas_end = ref_q && !o_ref_oe && !o_cap_oe;

  // Counts finished pairs since the last output change, and cycles between starts.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cap_q   <= 1'b0;
      sen_q   <= 1'b0;
      ref_q   <= 1'b0;
      therm_q <= 1'b0;
      gap_v_q <= 1'b0;
      ends_q  <= 3'h0;
      gap_q   <= 0;
    end else begin
      cap_q   <= o_cap_oe;
      sen_q   <= o_sense_oe;
      ref_q   <= o_ref_oe;
      therm_q <= o_thermostat;
      gap_q   <= start ? 1 : gap_q + 1;
      if (start) gap_v_q <= 1'b1;
      if (o_thermostat != therm_q) ends_q <= 3'h0;
      else if (meas_end && ends_q != 3'h7) ends_q <= ends_q + 3'h1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  AST_MIP_COVERS_PINS: assert property ((o_cap_oe || o_sense_oe || o_ref_oe) |->
    o_measuring_indicator) else $error("indicator low while a pin is driven");
  AST_ONE_DRIVER: assert property (!(o_sense_oe && o_ref_oe) &&
    !(o_cap_oe && (o_sense_oe || o_ref_oe))) else $error("two drivers on the cap node");
  AST_PRECHARGE: assert property ($rose(o_sense_oe || o_ref_oe) |-> $past(o_cap_oe) &&
    $past(o_cap_oe, P_PRECHG_CYC - 1) && ($past(o_cap_drv) != (o_sense_oe ? o_sense_drv :
    o_ref_drv))) else $error("timing began without forcing the cap pin");
  AST_THERM_AFTER_PAIR: assert property ($changed(o_thermostat) |->
    $past(meas_end) || $past(meas_end, 2) || $past(meas_end, 3))
    else $error("thermostat moved away from a finished measurement");
  AST_DEBOUNCE: assert property ($changed(o_thermostat) |-> ends_q >= 3'h3)
    else $error("thermostat changed after fewer than three measurements");
  AST_PERIOD: assert property (start && gap_v_q |->
    (gap_q == P_PERIOD_CYC) || (gap_q == P_FAST_CYC)) else $error("measurement spacing off");
  AST_RESET_QUIET: assert property (disable iff (1'b0) !i_rst_n |-> !o_thermostat &&
    !o_measuring_indicator && !o_cap_oe && !o_sense_oe && !o_ref_oe)
    else $error("outputs active during reset");
  AST_RESTART: assert property ($rose(i_rst_n) |-> ##[1:8] start)
    else $error("no fresh measurement after reset");

  COV_RISE: cover property ($rose(o_thermostat));
  COV_FALL: cover property ($fell(o_thermostat));
  COV_FAST: cover property (start && gap_v_q && gap_q == P_FAST_CYC);
endmodule : rtc_monitor

bind rtc_core rtc_monitor #(
  .P_PERIOD_CYC(P_PERIOD_CYC), .P_FAST_CYC(P_FAST_CYC), .P_PRECHG_CYC(P_PRECHG_CYC)
) rtc_monitor_inst (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cap_in(i_cap_in), .o_cap_drv(o_cap_drv),
  .o_cap_oe(o_cap_oe), .o_sense_drv(o_sense_drv), .o_sense_oe(o_sense_oe),
  .o_ref_drv(o_ref_drv), .o_ref_oe(o_ref_oe),
  .o_measuring_indicator(o_measuring_indicator), .o_thermostat(o_thermostat)
);

// File: tb/rtc_rc_model.sv
/*
  Behavioural resistor and capacitor network on the far side of the core.
  Assumes the bench sets the half times in clock cycles; an open input never crosses.
*/
`timescale 1ns/1ps

module rtc_rc_model (
  input  wire logic i_mclk,
  input  wire logic i_cap_drv,
  input  wire logic i_cap_oe,
  input  wire logic i_sense_drv,
  input  wire logic i_sense_oe,
  input  wire logic i_ref_drv,
  input  wire logic i_ref_oe,
  input  int        i_sense_half,
  input  int        i_ref_half,
  input  wire logic i_open,
  output logic      o_cap_in
);
  int cnt;

  initial begin
    o_cap_in = 1'b0;
    cnt      = 0;
  end

  // Forced node follows the cap pin; otherwise it crosses after the set time.
  always @(posedge i_mclk) begin
    #1;
    if (i_cap_oe) begin
      o_cap_in = i_cap_drv;
      cnt      = 0;
    end else if (i_sense_oe || i_ref_oe) begin
      cnt++;
      if (!i_open && cnt >= (i_sense_oe ? i_sense_half : i_ref_half))
        o_cap_in = i_sense_oe ? i_sense_drv : i_ref_drv;
    end
  end
endmodule : rtc_rc_model

// File: tb/tb_top.sv
/*
  Self-checking bench for the thermostat core with the network model.
  Assumes shortened timing parameters; every expectation derives from them.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end

module tb_top;
  import rtc_pkg::*;
  localparam int PER   = 6000;
  localparam int FAST  = 3000;
  localparam int LIMIT = 98000;
  logic i_mclk;
  logic i_rst_n;
  logic open_c;
  logic exp_v;
  logic mp;
  wire  cap_in;
  logic cap_drv, cap_oe, sen_drv, sen_oe, ref_drv, ref_oe, measuring_indicator, therm;
  logic cap_p, sen_p, ref_p;
  int   sense_half, ref_half, mismatches, checked, cyc, last_start, last_gap, toggles;
  logic exp_q[$];

  rtc_core #(.P_PERIOD_CYC(PER), .P_FAST_CYC(FAST), .P_PRECHG_CYC(10),
    .P_TIMEOUT_CYC(1600), .P_BLINK_CYC(20)) rtc_core_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cap_in(cap_in), .o_cap_drv(cap_drv),
    .o_cap_oe(cap_oe), .o_sense_drv(sen_drv), .o_sense_oe(sen_oe), .o_ref_drv(ref_drv),
    .o_ref_oe(ref_oe), .o_measuring_indicator(measuring_indicator), .o_thermostat(therm));

  rtc_rc_model rtc_rc_model_inst (
    .i_mclk(i_mclk), .i_cap_drv(cap_drv), .i_cap_oe(cap_oe), .i_sense_drv(sen_drv),
    .i_sense_oe(sen_oe), .i_ref_drv(ref_drv), .i_ref_oe(ref_oe), .i_sense_half(sense_half),
    .i_ref_half(ref_half), .i_open(open_c), .o_cap_in(cap_in));

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  task automatic stop_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  function automatic int rnd(input int base);
    return base + int'($urandom % 40);
  endfunction : rnd

  // Start spacing and the hang guard; a hung wait would otherwise never end.
  always @(posedge i_mclk) begin
    cyc++;
    if (cap_oe && !cap_p && !sen_p && !ref_p) begin
      last_gap   = cyc - last_start;
      last_start = cyc;
    end
    cap_p = cap_oe;
    sen_p = sen_oe;
    ref_p = ref_oe;
    if (cyc == LIMIT) begin
      mismatches++;
      stop_test();
    end
  end

  // Outside logic reads the result once the busy indicator has dropped.
  always @(negedge measuring_indicator) begin
    repeat (2) @(posedge i_mclk);
    #1;
    if (exp_q.size() > 0) begin
      exp_v = exp_q.pop_front();
      `CHK(therm, exp_v)
    end
  end

  // One measurement: set the network, note the expected output, wait for the end.
  task automatic meas(input int sh, input int rh, input logic op, input logic ex,
                      input int gap);
    sense_half = sh;
    ref_half   = rh;
    open_c     = op;
    @(posedge sen_oe);
    exp_q.push_back(ex);
    @(negedge measuring_indicator);
    repeat (4) @(posedge i_mclk);
    #1;
    if (gap != 0) `CHK(last_gap, gap)
  endtask : meas

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    open_c     = 1'b0;
    sense_half = 1300;
    ref_half   = 1300;
    mismatches = 0;
    checked    = 0;
    cyc        = 0;
    last_start = 0;
    last_gap   = 0;
    cap_p      = 1'b0;
    sen_p      = 1'b0;
    ref_p      = 1'b0;
    void'($urandom(32'h8cda64eb));
    // Assert reset once every process waits, so its falling edge is seen.
    #1 i_rst_n = 1'b0;
    repeat (5) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    meas(rnd(1320), rnd(1260), 1'b0, 1'b0, 0);
    // Reset in mid-charge must drop everything and forget the first count.
    @(posedge sen_oe);
    exp_q.push_back(1'b0);
    repeat (200) @(posedge i_mclk);
    #1 i_rst_n = 1'b0;
    @(posedge i_mclk);
    #1 `CHK({therm, measuring_indicator, cap_oe, sen_oe, ref_oe}, 5'h00)
    repeat (2) @(posedge i_mclk);
    #1 i_rst_n = 1'b1;
    meas(rnd(1320), rnd(1260), 1'b0, 1'b0, 0);
    meas(rnd(1320), rnd(1260), 1'b0, 1'b0, PER);
    meas(rnd(1320), rnd(1260), 1'b0, 1'b1, 0);
    meas(rnd(1250), 1420, 1'b0, 1'b1, 0);
    meas(rnd(1250), 1420, 1'b0, 1'b1, 0);
    meas(rnd(1340), 1420, 1'b0, 1'b1, 0);
    meas(rnd(1250), 1420, 1'b0, 1'b1, 0);
    meas(rnd(1250), 1420, 1'b0, 1'b1, 0);
    meas(rnd(1250), 1420, 1'b0, 1'b0, 0);
    meas(1300, 1300, 1'b1, 1'b0, 0);
    toggles = 0;
    mp      = measuring_indicator;
    repeat (400) begin
      @(posedge i_mclk);
      #1;
      if (measuring_indicator !== mp) toggles++;
      mp = measuring_indicator;
    end
    `CHK(toggles inside {[19:21]}, 1'b1)
    meas(1300, 1300, 1'b1, 1'b0, 0);
    meas(rnd(1320), rnd(1260), 1'b0, 1'b0, FAST);
    stop_test();
  end
endmodule : tb_top
